//--- verilog/pvio_pkg.sv
// Notes on behaviour
// - input level register ignores all writes
// - input register reads buffered levels, bits 7-0
// - pins sampled even while driven as outputs
// - direction bit 1 output, 0 input
// - motor pwm forces output on every pin
// - pin 6 output when timer ch3 compare
// - pin 4 output when timer ch2 compare
// - pin 3 i2c gives open-drain output
// - pin 3 pwm seven channel forces output
// - pin 3 pwm seven shutdown forces input
// - pin 3 spi then decides direction
// - pin 2 output when timer ch1 compare
// - pin 2 spi then decides direction
// - pin 2 pwm six forces output
// - reads may lag direction change three cycles
// - data read: register if output, else pin
package pvio_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // widths and register map
  localparam int unsigned PVIO_PINS = 8;
  localparam int unsigned PVIO_ADDR_W = 4;
  localparam logic [3:0] PVIO_OFS_OUTPUT_DATA = 4'h0;
  localparam logic [3:0] PVIO_OFS_INPUT_LEVELS = 4'h1;
  localparam logic [3:0] PVIO_OFS_PIN_DIRECTION = 4'h2;
  localparam logic [3:0] PVIO_OFS_OVERRIDE = 4'h3;

  // reset values
  localparam logic [7:0] PVIO_RST_DIRECTION = 8'h00;
  localparam logic [7:0] PVIO_RST_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] PVIO_RST_READ = 8'h00;

  // pin positions with special overrides
  localparam int unsigned PVIO_PIN_TIM3 = 6;
  localparam int unsigned PVIO_PIN_TIM2 = 4;
  localparam int unsigned PVIO_PIN_SHARED = 3;
  localparam int unsigned PVIO_PIN_CLOCK = 2;
  localparam int unsigned PVIO_TIM_CH_PIN6 = 3;
  localparam int unsigned PVIO_TIM_CH_PIN4 = 2;
  localparam int unsigned PVIO_TIM_CH_PIN2 = 1;
  localparam int unsigned PVIO_TIM_CHANNELS = 4;

  // synchroniser depth behind the pins
  localparam int unsigned PVIO_SYNC_STAGES = 2;

endpackage : pvio_pkg

//--- verilog/pvio_ctrl_if.sv
`timescale 1ns/10ps
// direction and drive values between register file and pin resolver
interface pvio_ctrl_if;
  logic [7:0] direction;
  logic [7:0] output_data;
  logic [7:0] drive_en;
  logic [7:0] drive_val;
  logic [7:0] forced;

  modport regs
  (
    output direction,
    output output_data,
    input drive_en,
    input drive_val,
    input forced
  );

  modport resolver
  (
    input direction,
    input output_data,
    output drive_en,
    output drive_val,
    output forced
  );
endinterface : pvio_ctrl_if

//--- verilog/pvio_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for the pin input levels
module pvio_sync
  import pvio_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // raw and buffered levels
  input wire logic [WIDTH-1:0] raw_level,
  output logic [WIDTH-1:0] buffered_level
);

  typedef struct packed {
    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] stage_two;
  } pvio_sync_state_type;

  pvio_sync_state_type state;
  pvio_sync_state_type next_state;

  //////////////////////////////////////////////////////////////////////////////
  // pins sampled regardless of direction
  always_comb
  begin
    next_state.stage_one = raw_level;
    next_state.stage_two = state.stage_one;
  end

  // register stages
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign buffered_level = state.stage_two;

endmodule : pvio_sync

//--- verilog/pvio_resolve.sv
`timescale 1ns/10ps
// per-pin direction and drive value by fixed priority
module pvio_resolve
  import pvio_pkg::*;
(
  // register side
  pvio_ctrl_if.resolver ctrl,
  // motor driver pwm
  input wire logic [7:0] motor_pwm_enable,
  input wire logic [7:0] motor_pwm_out,
  // timer_one output compare
  input wire logic [pvio_pkg::PVIO_TIM_CHANNELS-1:0] timer_one_oc_enable,
  input wire logic [pvio_pkg::PVIO_TIM_CHANNELS-1:0] timer_one_oc_out,
  // two_wire_i2c data line
  input wire logic two_wire_i2c_routed,
  input wire logic two_wire_i2c_enable,
  input wire logic two_wire_i2c_sda_out,
  // pwm channels seven and six
  input wire logic pwm_channel_seven_routed,
  input wire logic pwm_channel_seven_shutdown,
  input wire logic pwm_channel_seven_out,
  input wire logic pwm_channel_six_routed,
  input wire logic pwm_channel_six_out,
  // spi select and clock
  input wire logic spi_routed,
  input wire logic spi_enable,
  input wire logic spi_ss_drive,
  input wire logic spi_ss_out,
  input wire logic spi_sck_drive,
  input wire logic spi_sck_out,
  // open-drain marker per pin
  output logic [7:0] open_drain
);

  logic spi_active;

  assign spi_active = spi_routed & spi_enable;

  //////////////////////////////////////////////////////////////////////////////
  // priority chain per pin
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      ctrl.drive_en[i] = ctrl.direction[i];
      ctrl.drive_val[i] = ctrl.output_data[i];
      ctrl.forced[i] = 1'b0;
      open_drain[i] = 1'b0;
    end
    // pin 6: timer channel 3
    if (timer_one_oc_enable[PVIO_TIM_CH_PIN6])
    begin
      ctrl.drive_en[PVIO_PIN_TIM3] = 1'b1;
      ctrl.drive_val[PVIO_PIN_TIM3] = timer_one_oc_out[PVIO_TIM_CH_PIN6];
      ctrl.forced[PVIO_PIN_TIM3] = 1'b1;
    end
    // pin 4: timer channel 2
    if (timer_one_oc_enable[PVIO_TIM_CH_PIN4])
    begin
      ctrl.drive_en[PVIO_PIN_TIM2] = 1'b1;
      ctrl.drive_val[PVIO_PIN_TIM2] = timer_one_oc_out[PVIO_TIM_CH_PIN4];
      ctrl.forced[PVIO_PIN_TIM2] = 1'b1;
    end
    // pin 3: i2c, pwm seven, spi select
    if (two_wire_i2c_routed && two_wire_i2c_enable)
    begin
      ctrl.drive_en[PVIO_PIN_SHARED] = ~two_wire_i2c_sda_out;
      ctrl.drive_val[PVIO_PIN_SHARED] = 1'b0;
      ctrl.forced[PVIO_PIN_SHARED] = 1'b1;
      open_drain[PVIO_PIN_SHARED] = 1'b1;
    end
    else if (pwm_channel_seven_routed && !pwm_channel_seven_shutdown)
    begin
      ctrl.drive_en[PVIO_PIN_SHARED] = 1'b1;
      ctrl.drive_val[PVIO_PIN_SHARED] = pwm_channel_seven_out;
      ctrl.forced[PVIO_PIN_SHARED] = 1'b1;
    end
    else if (pwm_channel_seven_routed)
    begin
      ctrl.drive_en[PVIO_PIN_SHARED] = 1'b0;
      ctrl.forced[PVIO_PIN_SHARED] = 1'b1;
    end
    else if (spi_active)
    begin
      ctrl.drive_en[PVIO_PIN_SHARED] = spi_ss_drive;
      ctrl.drive_val[PVIO_PIN_SHARED] = spi_ss_out;
      ctrl.forced[PVIO_PIN_SHARED] = 1'b1;
    end
    // pin 2: timer channel 1, spi clock, pwm six
    if (timer_one_oc_enable[PVIO_TIM_CH_PIN2])
    begin
      ctrl.drive_en[PVIO_PIN_CLOCK] = 1'b1;
      ctrl.drive_val[PVIO_PIN_CLOCK] = timer_one_oc_out[PVIO_TIM_CH_PIN2];
      ctrl.forced[PVIO_PIN_CLOCK] = 1'b1;
    end
    else if (spi_active)
    begin
      ctrl.drive_en[PVIO_PIN_CLOCK] = spi_sck_drive;
      ctrl.drive_val[PVIO_PIN_CLOCK] = spi_sck_out;
      ctrl.forced[PVIO_PIN_CLOCK] = 1'b1;
    end
    else if (pwm_channel_six_routed)
    begin
      ctrl.drive_en[PVIO_PIN_CLOCK] = 1'b1;
      ctrl.drive_val[PVIO_PIN_CLOCK] = pwm_channel_six_out;
      ctrl.forced[PVIO_PIN_CLOCK] = 1'b1;
    end
    // motor pwm wins on every pin
    for (int i = 0; i < 8; i++)
    begin
      if (motor_pwm_enable[i])
      begin
        ctrl.drive_en[i] = 1'b1;
        ctrl.drive_val[i] = motor_pwm_out[i];
        ctrl.forced[i] = 1'b1;
        open_drain[i] = 1'b0;
      end
    end
  end

endmodule : pvio_resolve

//--- verilog/pvio_top.sv
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// port v pin direction, output data and input sampling
module pvio_top
  import pvio_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [pvio_pkg::PVIO_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  // motor driver pwm
  input wire logic [7:0] motor_pwm_enable,
  input wire logic [7:0] motor_pwm_out,
  // timer_one output compare
  input wire logic [pvio_pkg::PVIO_TIM_CHANNELS-1:0] timer_one_oc_enable,
  input wire logic [pvio_pkg::PVIO_TIM_CHANNELS-1:0] timer_one_oc_out,
  // two_wire_i2c data line
  input wire logic two_wire_i2c_routed,
  input wire logic two_wire_i2c_enable,
  input wire logic two_wire_i2c_sda_out,
  // pwm channels seven and six
  input wire logic pwm_channel_seven_routed,
  input wire logic pwm_channel_seven_shutdown,
  input wire logic pwm_channel_seven_out,
  input wire logic pwm_channel_six_routed,
  input wire logic pwm_channel_six_out,
  // spi select and clock
  input wire logic spi_routed,
  input wire logic spi_enable,
  input wire logic spi_ss_drive,
  input wire logic spi_ss_out,
  input wire logic spi_sck_drive,
  input wire logic spi_sck_out,
  // buffered levels for peripherals and open-drain flags
  output logic [7:0] pin_level,
  output logic [7:0] pin_open_drain
);

  typedef struct packed {
    logic [7:0] direction;
    logic [7:0] output_data;
    logic [7:0] rdata;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic [7:0] open_drain;
  } pvio_top_state_type;

  pvio_top_state_type state;
  pvio_top_state_type next_state;
  logic [7:0] buffered_level;
  logic [7:0] open_drain_comb;

  pvio_ctrl_if ctrl ();

  //////////////////////////////////////////////////////////////////////////////
  // input synchroniser
  pvio_sync #(
    .WIDTH(PVIO_PINS)
  ) i_pvio_sync (
    .core_clk(core_clk),
    .rst(rst),
    .raw_level(pin_in),
    .buffered_level(buffered_level)
  );

  // direction override resolution
  pvio_resolve i_pvio_resolve (
    .ctrl(ctrl.resolver),
    .motor_pwm_enable(motor_pwm_enable),
    .motor_pwm_out(motor_pwm_out),
    .timer_one_oc_enable(timer_one_oc_enable),
    .timer_one_oc_out(timer_one_oc_out),
    .two_wire_i2c_routed(two_wire_i2c_routed),
    .two_wire_i2c_enable(two_wire_i2c_enable),
    .two_wire_i2c_sda_out(two_wire_i2c_sda_out),
    .pwm_channel_seven_routed(pwm_channel_seven_routed),
    .pwm_channel_seven_shutdown(pwm_channel_seven_shutdown),
    .pwm_channel_seven_out(pwm_channel_seven_out),
    .pwm_channel_six_routed(pwm_channel_six_routed),
    .pwm_channel_six_out(pwm_channel_six_out),
    .spi_routed(spi_routed),
    .spi_enable(spi_enable),
    .spi_ss_drive(spi_ss_drive),
    .spi_ss_out(spi_ss_out),
    .spi_sck_drive(spi_sck_drive),
    .spi_sck_out(spi_sck_out),
    .open_drain(open_drain_comb)
  );

  assign ctrl.direction = state.direction;
  assign ctrl.output_data = state.output_data;

  //////////////////////////////////////////////////////////////////////////////
  // register writes, reads and pin drive
  always_comb
  begin
    next_state = state;
    // writes; the input level register takes none
    if (reg_write)
    begin
      case (reg_addr)
        PVIO_OFS_OUTPUT_DATA: next_state.output_data = reg_wdata;
        PVIO_OFS_PIN_DIRECTION: next_state.direction = reg_wdata;
        default: next_state.output_data = state.output_data;
      endcase
    end
    // read data stands only in the cycle after the strobe
    next_state.rdata = PVIO_RST_READ;
    if (reg_read)
    begin
      case (reg_addr)
        PVIO_OFS_OUTPUT_DATA: next_state.rdata =
          (state.direction & state.output_data) | (~state.direction & buffered_level);
        PVIO_OFS_INPUT_LEVELS: next_state.rdata = buffered_level;
        PVIO_OFS_PIN_DIRECTION: next_state.rdata = state.direction;
        PVIO_OFS_OVERRIDE: next_state.rdata = ctrl.forced;
        default: next_state.rdata = PVIO_RST_READ;
      endcase
    end
    // pins: output enable low while driving
    next_state.pin_out = ctrl.drive_val;
    next_state.pin_oe_n = ~ctrl.drive_en;
    next_state.open_drain = open_drain_comb;
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state.direction <= PVIO_RST_DIRECTION;
      state.output_data <= PVIO_RST_OUTPUT_DATA;
      state.rdata <= PVIO_RST_READ;
      state.pin_out <= 8'h00;
      state.pin_oe_n <= 8'hff;
      state.open_drain <= 8'h00;
    end
    else
    begin
      state <= next_state;
    end
  end

  // outputs
  assign reg_rdata = state.rdata;
  assign pin_out = state.pin_out;
  assign pin_oe_n = state.pin_oe_n;
  assign pin_open_drain = state.open_drain;
  assign pin_level = buffered_level;

endmodule : pvio_top

//--- verification/pvio_properties.sv
`timescale 1ns/10ps
// concurrent checks on the port v pin block, seen from its ports
module pvio_properties
  import pvio_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [pvio_pkg::PVIO_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pin_level,
  input wire logic [7:0] pin_open_drain,
  // peripheral requests
  input wire logic [7:0] motor_pwm_enable,
  input wire logic [7:0] motor_pwm_out,
  input wire logic [pvio_pkg::PVIO_TIM_CHANNELS-1:0] timer_one_oc_enable,
  input wire logic two_wire_i2c_routed,
  input wire logic two_wire_i2c_enable,
  input wire logic two_wire_i2c_sda_out,
  input wire logic pwm_channel_seven_routed,
  input wire logic pwm_channel_seven_shutdown,
  input wire logic pwm_channel_six_routed,
  input wire logic spi_routed,
  input wire logic spi_enable,
  input wire logic spi_ss_drive,
  input wire logic spi_sck_drive
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  // claims on the shared pin 3 and on pin 2 below the motor pwm
  logic i2c_on;
  logic p7_on;
  logic spi3_on;
  logic clk2_free;
  assign i2c_on = !motor_pwm_enable[3] && two_wire_i2c_routed && two_wire_i2c_enable;
  assign p7_on = !motor_pwm_enable[3] && !(two_wire_i2c_routed && two_wire_i2c_enable) && pwm_channel_seven_routed;
  // spi owns pin 3 only below motor pwm, i2c and pwm seven
  assign spi3_on = !motor_pwm_enable[3] && !(two_wire_i2c_routed && two_wire_i2c_enable) && !pwm_channel_seven_routed
    && spi_routed && spi_enable;
  // pin 2 free of motor pwm and timer compare
  assign clk2_free = !motor_pwm_enable[2] && !timer_one_oc_enable[1];
  //////////////////////////////////////////////////////////////////////////////
  // properties
  property p_lvl; !$past(rst) && !$past(rst, 2) |-> pin_level == $past(pin_in, 2); endproperty
  a_lvl: assert property (p_lvl) else $error("pin level lags pin input wrongly");
  property p_rd_in; reg_read && reg_addr == PVIO_OFS_INPUT_LEVELS |=> reg_rdata == $past(pin_level); endproperty
  a_rd_in: assert property (p_rd_in) else $error("input register read wrong");
  property p_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside its cycle");
  property p_motor; 1'b1 |=> (~pin_oe_n & $past(motor_pwm_enable)) == $past(motor_pwm_enable)
    && (pin_out & $past(motor_pwm_enable)) == ($past(motor_pwm_out) & $past(motor_pwm_enable)); endproperty
  a_motor: assert property (p_motor) else $error("motor pwm not driving");
  property p_t6; !motor_pwm_enable[6] && timer_one_oc_enable[3] |=> !pin_oe_n[6]; endproperty
  a_t6: assert property (p_t6) else $error("pin 6 compare not output");
  property p_t4; !motor_pwm_enable[4] && timer_one_oc_enable[2] |=> !pin_oe_n[4]; endproperty
  a_t4: assert property (p_t4) else $error("pin 4 compare not output");
  property p_t2; !motor_pwm_enable[2] && timer_one_oc_enable[1] |=> !pin_oe_n[2]; endproperty
  a_t2: assert property (p_t2) else $error("pin 2 compare not output");
  property p_i2c; i2c_on |=> pin_open_drain[3] && pin_oe_n[3] == $past(two_wire_i2c_sda_out) && !pin_out[3];
  endproperty
  a_i2c: assert property (p_i2c) else $error("pin 3 not open drain");
  property p_p7; p7_on && !pwm_channel_seven_shutdown |=> !pin_oe_n[3]; endproperty
  a_p7: assert property (p_p7) else $error("pin 3 pwm not output");
  property p_sd; p7_on && pwm_channel_seven_shutdown |=> pin_oe_n[3]; endproperty
  a_sd: assert property (p_sd) else $error("pin 3 shutdown not input");
  property p_spi3; spi3_on |=> pin_oe_n[3] == !$past(spi_ss_drive); endproperty
  a_spi3: assert property (p_spi3) else $error("pin 3 spi direction wrong");
  property p_spi2; clk2_free && spi_routed && spi_enable |=> pin_oe_n[2] == !$past(spi_sck_drive); endproperty
  a_spi2: assert property (p_spi2) else $error("pin 2 spi direction wrong");
  property p_p6; clk2_free && !(spi_routed && spi_enable) && pwm_channel_six_routed |=> !pin_oe_n[2]; endproperty
  a_p6: assert property (p_p6) else $error("pin 2 pwm six not output");
  property p_dir; reg_write && reg_addr == PVIO_OFS_PIN_DIRECTION ##1 !motor_pwm_enable[0]
    |=> pin_oe_n[0] == !$past(reg_wdata[0], 2); endproperty
  a_dir: assert property (p_dir) else $error("direction bit not applied");
  property p_rst; disable iff (1'b0) rst |=> pin_oe_n == 8'hff && reg_rdata == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : pvio_properties

//--- verification/pvio_pin_model.sv
`timescale 1ns/10ps
// pins from outside: driven bits follow the port, released or shorted bits the outside level
module pvio_pin_model
(
  // port side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  // outside world
  input wire logic [7:0] ext_level,
  input wire logic [7:0] short_mask,
  output logic [7:0] pin_in
);
  // a shorted pin is held by the outside even while driven; open drain releases to the pull level
  assign pin_in = (~pin_oe_n & ~short_mask & pin_out) | ((pin_oe_n | short_mask) & ext_level);
endmodule : pvio_pin_model

//--- verification/pvio_top_tb.sv
`timescale 1ns/10ps
// self-checking bench for the port v pin block
module pvio_top_tb;
  import pvio_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata, pin_out, pin_oe_n, pin_level, pin_open_drain;
  wire logic [7:0] pin_in;
  logic [7:0] ext_level = 8'h00, short_mask = 8'h00, motor_pwm_enable = 8'h00, motor_pwm_out = 8'h00;
  logic [3:0] timer_one_oc_enable = 4'h0, timer_one_oc_out = 4'h0;
  logic two_wire_i2c_routed = 1'b0, two_wire_i2c_enable = 1'b0, two_wire_i2c_sda_out = 1'b0, spi_routed = 1'b0;
  logic pwm_channel_seven_routed = 1'b0, pwm_channel_seven_shutdown = 1'b0, pwm_channel_seven_out = 1'b0;
  logic pwm_channel_six_routed = 1'b0, pwm_channel_six_out = 1'b0, spi_enable = 1'b0, spi_ss_drive = 1'b0;
  logic spi_ss_out = 1'b0, spi_sck_drive = 1'b0, spi_sck_out = 1'b0, rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] d, dir, x, s, drv, lvl;
  int err_total = 0, compares = 0, cycles = 0;
  //////////////////////////////////////////////////////////////////////////////
  // design, pins and clock
  pvio_top i_pvio_top (.*);
  pvio_pin_model i_pvio_pin_model (.*);
  always #12.5 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  task automatic test_done();
    $display("counts compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////////
  // read monitor: oldest note against the data standing after a read
  always @(negedge core_clk)
  begin
    if (rd_seen)
      check(reg_rdata, exp_q.pop_front());
    rd_seen = reg_read;
  end
  // hang guard
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      err_total = err_total + 1;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(32'h2f5d));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(PVIO_OFS_PIN_DIRECTION, PVIO_RST_DIRECTION);
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($urandom);
      dir = 8'($urandom);
      x = 8'($urandom);
      s = 8'($urandom) & 8'($urandom);
      ext_level <= x;
      short_mask <= s;
      wr(PVIO_OFS_OUTPUT_DATA, d);
      wr(PVIO_OFS_PIN_DIRECTION, dir);
      wr(PVIO_OFS_INPUT_LEVELS, ~d);
      repeat (4) @(posedge core_clk);
      drv = dir & ~s;
      lvl = (drv & d) | (~drv & x);
      rd(PVIO_OFS_INPUT_LEVELS, lvl);
      rd(PVIO_OFS_OUTPUT_DATA, (dir & d) | (~dir & lvl));
      rd(PVIO_OFS_PIN_DIRECTION, dir);
      rd(4'hf, 8'h00);
    end
    $display("test registers and levels done");
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(PVIO_OFS_PIN_DIRECTION, PVIO_RST_DIRECTION);
    $display("test mid-run reset done");
    // random peripheral claims, judged by the checker
    repeat (300)
    begin
      @(posedge core_clk);
      motor_pwm_enable <= 8'($urandom & $urandom & $urandom);
      ext_level <= 8'($urandom);
      {motor_pwm_out, timer_one_oc_enable, timer_one_oc_out, two_wire_i2c_routed, two_wire_i2c_enable,
        two_wire_i2c_sda_out, pwm_channel_seven_routed, pwm_channel_seven_shutdown, pwm_channel_seven_out,
        pwm_channel_six_routed, pwm_channel_six_out, spi_routed, spi_enable, spi_ss_drive, spi_ss_out,
        spi_sck_drive, spi_sck_out} <= 30'($urandom);
    end
    // motor pwm on every pin: levels follow its outputs, all pins reported forced
    @(posedge core_clk);
    x = 8'($urandom);
    motor_pwm_enable <= 8'hff;
    motor_pwm_out <= x;
    short_mask <= 8'h00;
    repeat (4) @(posedge core_clk);
    rd(PVIO_OFS_INPUT_LEVELS, x);
    rd(PVIO_OFS_OVERRIDE, 8'hff);
    $display("test peripheral overrides done");
    test_done();
  end
endmodule : pvio_top_tb
bind pvio_top pvio_properties i_pvio_properties (.*);
